// *** include/lcd_pkg.sv ***
// shared constants, field positions and carrier types of the character display command block
package lcd_pkg;

	// clock and execution times
	localparam int CLK_PERIOD_NS  = 5;          // 200 MHz system clock
	localparam int LONG_EXEC_NS   = 1_520_000;  // clear and return-home, longest time
	localparam int SHORT_EXEC_NS  = 37_000;     // every other instruction and data access
	localparam int LONG_EXEC_CYC  = LONG_EXEC_NS / CLK_PERIOD_NS;   // rounds down
	localparam int SHORT_EXEC_CYC = SHORT_EXEC_NS / CLK_PERIOD_NS;  // rounds down
	localparam int CNT_W          = 19;         // holds the long count

	// structure sizes
	localparam int FIFO_DEPTH   = 4;            // words queued between bus and executor
	localparam int DISP_RAM_LEN = 128;          // display ram words (7-bit pointer)
	localparam int GLYPH_RAM_LEN = 64;          // glyph ram words (6-bit pointer)

	// fixed values
	localparam logic [7:0] SPACE_CODE = 8'h20;  // fill value of the clear command
	localparam logic [6:0] HOME_ADDR  = 7'h00;  // pointer after clear and return-home
	localparam logic [6:0] FILL_LAST  = 7'h7f;  // last display ram word to fill

	// instruction class bits, highest set bit wins
	localparam int CMD_DISPLAY_RAM_BIT = 7;
	localparam int CMD_GLYPH_RAM_BIT = 6;
	localparam int CMD_FUNC_BIT  = 5;
	localparam int CMD_SHIFT_BIT = 4;
	localparam int CMD_ONOFF_BIT = 3;
	localparam int CMD_ENTRY_BIT = 2;
	localparam int CMD_HOME_BIT  = 1;
	localparam int CMD_CLEAR_BIT = 0;

	// operand bit positions
	localparam int FUNC_WIDTH_BIT = 4;
	localparam int FUNC_LINES_BIT = 3;
	localparam int FUNC_FONT_BIT  = 2;
	localparam int SHIFT_SC_BIT   = 3;
	localparam int SHIFT_RL_BIT   = 2;
	localparam int ONOFF_D_BIT    = 2;
	localparam int ONOFF_C_BIT    = 1;
	localparam int ONOFF_B_BIT    = 0;
	localparam int ENTRY_ID_BIT   = 1;
	localparam int ENTRY_S_BIT    = 0;

	// reset values of the mode bits
	localparam logic RST_WIDE  = 1'b1;  // 8-bit bus after power-on
	localparam logic RST_INC   = 1'b1;  // pointer counts up
	localparam logic RST_SHEN  = 1'b0;  // no display shift on writes
	localparam logic RST_GLYPH = 1'b0;  // data goes to display ram

	// kind of queued host transfer
	typedef enum logic [1:0] {
		OP_INSTR = 2'h0,
		OP_WRITE = 2'h1,
		OP_READ  = 2'h2
	} lcd_op_kind_type;

	// one queued word
	typedef struct packed {
		lcd_op_kind_type kind;
		logic [7:0]      value;
	} lcd_op_type;

	// executor states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_FILL = 3'b010,
		ST_WAIT = 3'b100
	} lcd_state_type;

	// display settings seen by the panel drivers
	typedef struct packed {
		logic display_on;
		logic cursor_on;
		logic blink_on;
		logic two_line;
		logic tall_font;
	} lcd_view_type;

endpackage

// *** hw/lcd_fifo.sv ***
// small synchronous fifo with valid and ready on both sides
module lcd_fifo
	import lcd_pkg::*;
#(
	parameter int WIDTH = 10,  // word width
	parameter int DEPTH = 4    // words, a power of two
) (
	// clock and reset
	input  wire logic             clock,
	input  wire logic             rst_n,
	// filling side
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output wire logic             in_ready,
	// draining side
	output wire logic [WIDTH-1:0] out_data,
	output wire logic             out_valid,
	input  wire logic             out_ready
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];  // storage words
	logic [AW-1:0]    wr_q;           // next slot to write
	logic [AW-1:0]    rd_q;           // oldest slot
	logic [AW:0]      cnt_q;          // words held

	wire push = in_valid & in_ready;
	wire pop  = out_valid & out_ready;

	assign in_ready  = (cnt_q != (AW + 1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data  = mem_q[rd_q];

	// storage, no reset needed since empty slots are never read
	always_ff @(posedge clock) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	// pointers and fill level
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			wr_q  <= push ? wr_q + 1'b1 : wr_q;
			rd_q  <= pop ? rd_q + 1'b1 : rd_q;
			cnt_q <= cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
		end
	end

endmodule

// *** hw/lcd_cmd_if.sv ***
// host command and data interface of the character display controller
module lcd_cmd_if
	import lcd_pkg::*;
#(
	parameter int LONG_CYC  = LONG_EXEC_CYC,   // clear and return-home cycles
	parameter int SHORT_CYC = SHORT_EXEC_CYC   // other execution cycles
) (
	// clock and reset
	input  wire logic         clock,
	input  wire logic         rst_n,
	// host pins
	input  wire logic         target_select,
	input  wire logic         read_dir,
	input  wire logic         strobe,
	input  wire logic [7:0]   host_bus_lines_in,
	output wire logic [7:0]   host_bus_lines_out,
	output wire logic         host_bus_lines_oe,
	// display state
	output wire lcd_view_type display_view,
	output wire logic [6:0]   display_shift,
	output wire logic [6:0]   ram_pointer,
	output wire logic         engaged_flag
);

	// pin capture state
	logic         strobe_q;          // strobe one cycle ago
	logic         sel_q;             // target select seen while strobe high
	logic         dir_q;             // direction seen while strobe high
	logic [7:0]   bus_q;             // bus lines seen while strobe high
	logic         nibble_q;          // low nibble expected next in 4-bit mode
	logic [3:0]   high_q;            // first nibble of a 4-bit pair
	logic [7:0]   bus_out_q;         // word driven back to the host

	// mode and pointer state
	logic [6:0]   ptr_q, ptr_d;      // ram pointer
	logic         glyph_q, glyph_d;  // data targets glyph ram
	logic         wide_q, wide_d;    // 8-bit bus mode
	logic         inc_q, inc_d;      // pointer counts up
	logic         shen_q, shen_d;    // display shifts on display writes
	logic [6:0]   shift_q, shift_d;  // display shift offset
	lcd_view_type view_q, view_d;    // display settings
	logic [7:0]   xfer_q;            // ram transfer buffer

	// executor state
	lcd_state_type     state_q, state_d;
	logic [CNT_W-1:0]  cnt_q, cnt_d;  // execution countdown
	logic [6:0]        fill_q;        // clear fill address
	logic              long_op;       // popped op takes the long time
	logic              clear_op;      // popped op is clear

	// storage
	logic [7:0] display_ram [DISP_RAM_LEN];
	logic [7:0] glyph_ram   [GLYPH_RAM_LEN];

	// fifo links
	lcd_op_type op_in;
	lcd_op_type op;
	logic       fifo_in_ready;
	logic       fifo_out_valid;

	// strobe edges and latched transfer class
	wire strobe_rise = strobe & ~strobe_q;
	wire strobe_fall = ~strobe & strobe_q;
	wire is_instr_wr = ~sel_q & ~dir_q;
	wire is_status   = ~sel_q & dir_q;
	wire is_data_wr  = sel_q & ~dir_q;
	wire is_data_rd  = sel_q & dir_q;
	wire last_part   = wide_q | nibble_q;
	wire [7:0] whole = wide_q ? bus_q : {high_q, bus_q[7:4]};

	// a finished write or data read is queued for the executor while the queue has room
	wire push_req = strobe_fall & last_part & ~is_status;
	assign op_in.kind  = is_instr_wr ? OP_INSTR : (is_data_wr ? OP_WRITE : OP_READ);
	assign op_in.value = whole;

	// readback word: status or transfer buffer, never the instruction
	wire [7:0] rd_byte = target_select ? xfer_q : {engaged_flag, ptr_q};
	wire [7:0] rd_lane = wide_q ? rd_byte
		: {(nibble_q ? rd_byte[3:0] : rd_byte[7:4]), 4'h0};

	// executor hand-off
	wire pop      = (state_q == ST_IDLE) & fifo_out_valid;
	wire op_done  = (state_q == ST_WAIT) & (cnt_q == '0);
	wire fill_end = (state_q == ST_FILL) & (fill_q == FILL_LAST);
	wire dd_we    = pop & (op.kind == OP_WRITE) & ~glyph_q;
	wire cg_we    = pop & (op.kind == OP_WRITE) & glyph_q;

	// pointer step in the entry or cursor-shift direction, wrapping inside the selected ram
	function automatic logic [6:0] step(input logic [6:0] p, input logic up, input logic g);
		logic [6:0] n;
		n = up ? p + 7'h01 : p - 7'h01;
		return g ? {1'b0, n[5:0]} : n;
	endfunction

	// pins: device drives only during a read with strobe high
	assign host_bus_lines_oe  = strobe & read_dir;
	assign host_bus_lines_out = bus_out_q;
	assign display_view       = view_q;
	assign display_shift      = shift_q;
	assign ram_pointer        = ptr_q;
	// busy while executing, while words wait, or while the queue is full
	assign engaged_flag = (state_q != ST_IDLE) | fifo_out_valid | ~fifo_in_ready;

	// command queue between the host bus and the executor
	lcd_fifo #(
		.WIDTH ($bits(lcd_op_type)),
		.DEPTH (FIFO_DEPTH)
	) u_queue (
		.clock     (clock),
		.rst_n     (rst_n),
		.in_data   (op_in),
		.in_valid  (push_req),
		.in_ready  (fifo_in_ready),
		.out_data  (op),
		.out_valid (fifo_out_valid),
		.out_ready (state_q == ST_IDLE)
	);

	// pin capture and nibble pairing
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			strobe_q  <= 1'b0;
			sel_q     <= 1'b0;
			dir_q     <= 1'b0;
			bus_q     <= 8'h00;
			nibble_q  <= 1'b0;
			high_q    <= 4'h0;
			bus_out_q <= 8'h00;
		end else begin
			strobe_q <= strobe;
			if (strobe) begin
				sel_q <= target_select;
				dir_q <= read_dir;
				bus_q <= host_bus_lines_in;
			end
			// function set restarts the pairing; otherwise each falling edge in 4-bit mode flips it
			if (pop & (op.kind == OP_INSTR) & op.value[CMD_FUNC_BIT]
				& ~op.value[CMD_DISPLAY_RAM_BIT] & ~op.value[CMD_GLYPH_RAM_BIT]) begin
				nibble_q <= 1'b0;
			end else if (strobe_fall & ~wide_q) begin
				nibble_q <= ~nibble_q;
			end
			if (strobe_fall & ~nibble_q) begin
				high_q <= bus_q[7:4];
			end
			if (strobe_rise) begin
				bus_out_q <= rd_lane;
			end
		end
	end

	// next mode and pointer values from the popped word
	always_comb begin
		ptr_d    = ptr_q;
		glyph_d  = glyph_q;
		wide_d   = wide_q;
		inc_d    = inc_q;
		shen_d   = shen_q;
		shift_d  = shift_q;
		view_d   = view_q;
		long_op  = 1'b0;
		clear_op = 1'b0;
		if (pop) begin
			case (op.kind)
				OP_WRITE: begin
					ptr_d = step(ptr_q, inc_q, glyph_q);
					if (shen_q & ~glyph_q) begin
						shift_d = inc_q ? shift_q + 7'h01 : shift_q - 7'h01;
					end
				end
				OP_READ: begin
					ptr_d = step(ptr_q, inc_q, glyph_q);
				end
				default: begin
					if (op.value[CMD_DISPLAY_RAM_BIT]) begin
						ptr_d   = op.value[6:0];
						glyph_d = 1'b0;
					end else if (op.value[CMD_GLYPH_RAM_BIT]) begin
						ptr_d   = {1'b0, op.value[5:0]};
						glyph_d = 1'b1;
					end else if (op.value[CMD_FUNC_BIT]) begin
						wide_d           = op.value[FUNC_WIDTH_BIT];
						view_d.two_line  = op.value[FUNC_LINES_BIT];
						view_d.tall_font = op.value[FUNC_FONT_BIT];
					end else if (op.value[CMD_SHIFT_BIT]) begin
						// display shift leaves the pointer; cursor shift moves it
						if (op.value[SHIFT_SC_BIT]) begin
							shift_d = op.value[SHIFT_RL_BIT] ? shift_q - 7'h01
								: shift_q + 7'h01;
						end else begin
							ptr_d = step(ptr_q, op.value[SHIFT_RL_BIT], glyph_q);
						end
					end else if (op.value[CMD_ONOFF_BIT]) begin
						view_d.display_on = op.value[ONOFF_D_BIT];
						view_d.cursor_on  = op.value[ONOFF_C_BIT];
						view_d.blink_on   = op.value[ONOFF_B_BIT];
					end else if (op.value[CMD_ENTRY_BIT]) begin
						inc_d  = op.value[ENTRY_ID_BIT];
						shen_d = op.value[ENTRY_S_BIT];
					end else if (op.value[CMD_HOME_BIT]) begin
						ptr_d   = HOME_ADDR;
						glyph_d = 1'b0;
						shift_d = 7'h00;
						long_op = 1'b1;
					end else if (op.value[CMD_CLEAR_BIT]) begin
						ptr_d    = HOME_ADDR;
						glyph_d  = 1'b0;
						shift_d  = 7'h00;
						inc_d    = 1'b1;
						long_op  = 1'b1;
						clear_op = 1'b1;
					end
				end
			endcase
		end
	end

	// executor sequence: fill for clear while the execution count runs, then wait out the rest of it
	always_comb begin
		state_d = state_q;
		cnt_d   = (state_q == ST_IDLE) ? cnt_q : cnt_q - 1'b1;
		case (state_q)
			ST_IDLE: begin
				if (pop) begin
					state_d = clear_op ? ST_FILL : ST_WAIT;
					cnt_d   = long_op ? CNT_W'(LONG_CYC - 1) : CNT_W'(SHORT_CYC - 1);
				end
			end
			ST_FILL: begin
				if (fill_end) begin
					state_d = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (op_done) begin
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// mode, pointer and executor registers
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ptr_q   <= HOME_ADDR;
			glyph_q <= RST_GLYPH;
			wide_q  <= RST_WIDE;
			inc_q   <= RST_INC;
			shen_q  <= RST_SHEN;
			shift_q <= 7'h00;
			view_q  <= '0;
			state_q <= ST_IDLE;
			cnt_q   <= '0;
			fill_q  <= 7'h00;
		end else begin
			ptr_q   <= ptr_d;
			glyph_q <= glyph_d;
			wide_q  <= wide_d;
			inc_q   <= inc_d;
			shen_q  <= shen_d;
			shift_q <= shift_d;
			view_q  <= view_d;
			state_q <= state_d;
			cnt_q   <= cnt_d;
			fill_q  <= (state_q == ST_FILL) ? fill_q + 7'h01 : 7'h00;
		end
	end

	// ram writes: clear fill has the port to itself while it runs
	always_ff @(posedge clock) begin
		if (state_q == ST_FILL) begin
			display_ram[fill_q] <= SPACE_CODE;
		end else if (dd_we) begin
			display_ram[ptr_q] <= op.value;
		end
		if (cg_we) begin
			glyph_ram[ptr_q[5:0]] <= op.value;
		end
	end

	// transfer buffer reloads from the pointed word when an op finishes
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			xfer_q <= 8'h00;
		end else if (op_done) begin
			xfer_q <= glyph_q ? glyph_ram[ptr_q[5:0]] : display_ram[ptr_q];
		end
	end

	// checks
	a_status_word: assert property (@(posedge clock) disable iff (!rst_n)
		strobe_rise & ~target_select & wide_q |=> bus_out_q == {$past(engaged_flag), $past(ptr_q)})
		else $error("status word differs from busy and pointer");
	a_clear_home: assert property (@(posedge clock) disable iff (!rst_n)
		pop & clear_op |=> ptr_q == HOME_ADDR && state_q == ST_FILL && cnt_q == CNT_W'(LONG_CYC - 1))
		else $error("clear did not home pointer or start long time");
	a_home_shift: assert property (@(posedge clock) disable iff (!rst_n)
		pop & long_op & ~clear_op |=> ptr_q == HOME_ADDR && shift_q == 7'h00 && state_q == ST_WAIT)
		else $error("return home left pointer or shift");
	a_display_ram_set: assert property (@(posedge clock) disable iff (!rst_n)
		pop & (op.kind == OP_INSTR) & op.value[CMD_DISPLAY_RAM_BIT]
		|=> ptr_q == $past(op.value[6:0]) && !glyph_q)
		else $error("display address not loaded");
	a_glyph_ram_set: assert property (@(posedge clock) disable iff (!rst_n)
		pop & (op.kind == OP_INSTR) & (op.value[7:6] == 2'b01)
		|=> ptr_q == {1'b0, $past(op.value[5:0])} && glyph_q)
		else $error("glyph address not loaded");
	a_width_latch: assert property (@(posedge clock) disable iff (!rst_n)
		pop & (op.kind == OP_INSTR) & (op.value[7:5] == 3'b001)
		|=> wide_q == $past(op.value[FUNC_WIDTH_BIT]) && view_q.two_line == $past(op.value[3]))
		else $error("function set not latched");
	a_ptr_step: assert property (@(posedge clock) disable iff (!rst_n)
		pop & (op.kind == OP_WRITE) & ~glyph_q & inc_q |=> ptr_q == $past(ptr_q) + 7'h01)
		else $error("pointer did not step up after write");
	a_busy_hold: assert property (@(posedge clock) disable iff (!rst_n)
		pop |=> engaged_flag [*8])
		else $error("busy dropped during execution");
	a_no_instr_read: assert property (@(posedge clock) disable iff (!rst_n)
		strobe_rise & target_select & wide_q |=> bus_out_q == $past(xfer_q))
		else $error("data read word is not the transfer buffer");
	a_write_queue: assert property (@(posedge clock) disable iff (!rst_n)
		strobe_fall & wide_q & is_data_wr & fifo_in_ready |=> fifo_out_valid)
		else $error("data write not queued");

	c_clear_run: cover property (@(posedge clock) disable iff (!rst_n) fill_end);
	c_data_read: cover property (@(posedge clock) disable iff (!rst_n) pop & (op.kind == OP_READ));
	c_narrow_wr: cover property (@(posedge clock) disable iff (!rst_n)
		push_req & ~wide_q & is_data_wr);

endmodule

// *** tb/lcd_host_model.sv ***
// host model: drives select, direction, strobe and data lines like a processor
module lcd_host_model (
	// clock
	input  wire logic       clock,
	// host pins toward the device
	output var  logic       target_select,
	output var  logic       read_dir,
	output var  logic       strobe,
	output wire logic [7:0] bus_lines,
	// device drive of the data lines
	input  wire logic [7:0] dev_out,
	input  wire logic       dev_oe
);
	timeunit 1ns;
	timeprecision 100ps;

	logic       wide = 1'b1;  // bus width the host believes in
	logic       drv  = 1'b0;  // host drives the data lines
	logic [7:0] hv   = 8'h00; // value the host drives

	// resolved lines, pull-ups when nobody drives
	assign bus_lines = dev_oe ? dev_out : (drv ? hv : 8'hff);

	// idle levels at time zero
	initial begin
		target_select = 1'b0;
		read_dir = 1'b0;
		strobe = 1'b0;
	end

	// one strobe pulse, held two cycles, read word taken before release
	task automatic pulse(input logic s, input logic d, input logic [7:0] v,
		output logic [7:0] r);
		@(posedge clock);
		#1;
		target_select = s;
		read_dir = d;
		drv = !d;
		hv = v;
		strobe = 1'b1;
		repeat (2) @(posedge clock);
		r = bus_lines;
		#1;
		strobe = 1'b0;
		@(posedge clock);
		#1;
		drv = 1'b0;
	endtask

	// one byte, split in two nibbles on lines 7..4 when narrow
	task automatic xfer(input logic s, input logic d, input logic [7:0] v,
		output logic [7:0] r);
		logic [7:0] hi;
		logic [7:0] lo;
		if (wide) begin
			pulse(s, d, v, r);
		end else begin
			pulse(s, d, {v[7:4], 4'hf}, hi);
			pulse(s, d, {v[3:0], 4'hf}, lo);
			r = {hi[7:4], lo[7:4]};
		end
	endtask
endmodule

// *** tb/lcd_cmd_if_bench.sv ***
// self-checking bench of the host command interface
module lcd_cmd_if_bench;
	timeunit 1ns;
	timeprecision 100ps;

	logic               clock = 1'b0;  // 200 MHz
	logic               rst_n = 1'b0;  // async reset
	wire logic          ts;            // select pin
	wire logic          rdd;           // direction pin
	wire logic          stb;           // strobe pin
	wire logic [7:0]    bus_in;        // resolved data lines
	wire logic [7:0]    bus_out;       // device read word
	wire logic          oe;            // device drives lines
	lcd_pkg::lcd_view_type view;       // display settings
	wire logic [6:0]    shift;         // display shift offset
	wire logic [6:0]    ptr;           // address counter
	wire logic          eng;           // busy
	int                 miscompares = 0;
	int                 n_tests = 0;
	logic [7:0]         s;             // status or data seen
	logic [7:0]         t;             // unused read word
	logic [7:0] vc [5] = '{8'h3C, 8'h0C, 8'h0B, 8'h38, 8'h30};
	logic [4:0] ve [5] = '{5'h03, 5'h13, 5'h0F, 5'h0E, 5'h0C};
	logic [7:0] sc [5] = '{8'h10, 8'h14, 8'h18, 8'h1C, 8'h1C};
	logic [6:0] sp [5] = '{7'h0F, 7'h10, 7'h10, 7'h10, 7'h10};
	logic [6:0] ss [5] = '{7'h00, 7'h00, 7'h01, 7'h00, 7'h7F};

	// device with short execution counts
	lcd_cmd_if #(.LONG_CYC(200), .SHORT_CYC(20)) lcd_cmd_if_i (
		.clock(clock), .rst_n(rst_n), .target_select(ts), .read_dir(rdd),
		.strobe(stb), .host_bus_lines_in(bus_in), .host_bus_lines_out(bus_out),
		.host_bus_lines_oe(oe), .display_view(view), .display_shift(shift),
		.ram_pointer(ptr), .engaged_flag(eng));

	// processor on the far side
	lcd_host_model lcd_host_model_i (
		.clock(clock), .target_select(ts), .read_dir(rdd), .strobe(stb),
		.bus_lines(bus_in), .dev_out(bus_out), .dev_oe(oe));

	// clock generator
	initial begin
		forever #2.5 clock = ~clock;
	end

	task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic stat(output logic [7:0] v);
		lcd_host_model_i.xfer(1'b0, 1'b1, 8'h00, v);
	endtask

	// short settle wait, then poll busy under a bound
	task automatic idle();
		logic [7:0] v;
		repeat (4) @(posedge clock);
		for (int k = 0; k < 300; k++) begin
			stat(v);
			if (v[7] === 1'b0) return;
		end
		miscompares++;
		$display("MISMATCH busy expected 0 seen 1");
	endtask

	// instruction write; host follows the width it just set
	task automatic ins(input logic [7:0] c);
		logic [7:0] x;
		lcd_host_model_i.xfer(1'b0, 1'b0, c, x);
		if (c[7:5] === 3'b001) lcd_host_model_i.wide = c[4];
		idle();
	endtask

	task automatic wr(input logic [7:0] d);
		logic [7:0] x;
		lcd_host_model_i.xfer(1'b1, 1'b0, d, x);
		idle();
	endtask

	task automatic rd(output logic [7:0] v);
		lcd_host_model_i.xfer(1'b1, 1'b1, 8'h00, v);
		idle();
	endtask

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// watchdog
	initial begin
		repeat (90000) @(posedge clock);
		miscompares++;
		summarize();
	end

	// main sequence
	initial begin
		repeat (3) @(posedge clock);
		#1 rst_n = 1'b1;
		stat(s);
		chk("status", 8'h00, s);
		$display("test reset done");
		ins(8'h90);
		wr(8'h99);
		stat(s);
		chk("ptr", 8'h11, s);
		lcd_host_model_i.xfer(1'b0, 1'b0, 8'h01, t);
		stat(s);
		chk("busy", 8'h01, {7'h00, s[7]});
		repeat (150) @(posedge clock);
		stat(s);
		chk("busy late", 8'h01, {7'h00, s[7]});
		repeat (60) @(posedge clock);
		stat(s);
		chk("clear done", 8'h00, s);
		ins(8'h90);
		rd(s);
		chk("space", 8'h20, s);
		$display("test clear done");
		for (int i = 0; i < 5; i++) begin
			ins(vc[i]);
			chk("view", {3'h0, ve[i]}, {3'h0, view});
		end
		$display("test view done");
		ins(8'h85);
		stat(s);
		chk("ptr", 8'h05, s);
		wr(8'h41);
		wr(8'h42);
		stat(s);
		chk("ptr", 8'h07, s);
		ins(8'h85);
		rd(s);
		chk("data", 8'h41, s);
		rd(s);
		chk("prefetch", 8'h42, s);
		$display("test data done");
		ins(8'h04);
		ins(8'h90);
		wr(8'h33);
		stat(s);
		chk("ptr", 8'h0F, s);
		ins(8'h07);
		wr(8'h34);
		chk("shift", 8'h01, {1'b0, shift});
		ins(8'h03);
		chk("home", 8'h00, {1'b0, ptr});
		chk("home shift", 8'h00, {1'b0, shift});
		ins(8'h06);
		ins(8'h90);
		rd(s);
		chk("kept", 8'h33, s);
		$display("test entry done");
		ins(8'h90);
		for (int i = 0; i < 5; i++) begin
			ins(sc[i]);
			chk("ptr", {1'b0, sp[i]}, {1'b0, ptr});
			chk("shift", {1'b0, ss[i]}, {1'b0, shift});
		end
		ins(8'h1C);
		ins(8'h1C);
		$display("test shift done");
		ins(8'h7F);
		stat(s);
		chk("ptr", 8'h3F, s);
		wr(8'h55);
		stat(s);
		chk("wrap", 8'h00, s);
		ins(8'h7F);
		rd(s);
		chk("glyph", 8'h55, s);
		ins(8'hBF);
		rd(s);
		chk("display", 8'h20, s);
		$display("test glyph done");
		lcd_host_model_i.xfer(1'b0, 1'b0, 8'h01, t);
		for (int i = 1; i < 6; i++) begin
			lcd_host_model_i.xfer(1'b1, 1'b0, 8'(i), t);
		end
		stat(s);
		chk("busy", 8'h01, {7'h00, s[7]});
		idle();
		stat(s);
		chk("queued", 8'h04, s);
		ins(8'h83);
		rd(s);
		chk("last", 8'h04, s);
		rd(s);
		chk("dropped", 8'h20, s);
		$display("test queue done");
		ins(8'h28);
		chk("view", 8'h0E, {3'h0, view});
		ins(8'hA0);
		wr(8'hA5);
		stat(s);
		chk("ptr", 8'h21, s);
		ins(8'hA0);
		rd(s);
		chk("nibble", 8'hA5, s);
		ins(8'h30);
		stat(s);
		chk("wide", 8'h21, s);
		$display("test nibble done");
		// second reset in mid-run: pointer, settings and shift return to their reset values
		@(posedge clock);
		#1 rst_n = 1'b0;
		repeat (3) @(posedge clock);
		#1 rst_n = 1'b1;
		stat(s);
		chk("reset ptr", 8'h00, s);
		chk("reset view", 8'h00, {3'h0, view});
		chk("reset shift", 8'h00, {1'b0, shift});
		$display("test second reset done");
		summarize();
	end
endmodule
